// file: design/sac_ctrl.sv
// Digital control of a serial successive-approximation converter with input multiplexer.
// Assumes host pins and the comparator are asynchronous to pclk and sclk is far slower.
//
// Our own choices: the register offsets and the APB interface to the registers.
`default_nettype none
module sac_ctrl (
  // APB clock, reset and slave port.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins.
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        di_pin,
  output logic             do_pin,
  output logic             do_oe_n,
  // Power and comparator pins.
  input  wire logic        hw_powerdown_pin,
  input  wire logic        comp_pin,
  // Analog switch controls.
  output logic [3:0]       chan_pos_sel,
  output logic [3:0]       chan_neg_sel,
  output logic             com_neg_sel,
  output logic             comp_zero,
  output logic             feedback_open,
  output logic             cap_to_neg,
  output logic             bandgap_en,
  output logic [10:0]      dac_switch
);
  localparam int unsigned RB = sac_pkg::RESULT_BITS;
  localparam int unsigned AB = sac_pkg::ASSIGN_BITS;

  // Channel decode: {pos[3:0], neg[3:0], com}.
  function automatic logic [8:0] chan_decode(input logic [4:0] w, input logic four);
    logic [1:0] pos;
    logic [1:0] neg;
    logic [3:0] pos_oh;
    logic [3:0] neg_oh;
    pos    = {four & w[sac_pkg::BIT_LO], w[sac_pkg::BIT_ODD]};
    neg    = {four & w[sac_pkg::BIT_LO], ~w[sac_pkg::BIT_ODD]};
    pos_oh = 4'h1 << pos;
    neg_oh = 4'h1 << neg;
    if (!w[sac_pkg::BIT_RUN]) begin
      chan_decode = 9'h000;
    end else if (w[sac_pkg::BIT_ENDED]) begin
      chan_decode = {pos_oh, 4'h0, 1'b1};
    end else begin
      chan_decode = {pos_oh, neg_oh, 1'b0};
    end
  endfunction

  // Two-flop synchronisers for every pin input.
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       sclk_d;
  logic       cs_n_s;
  logic       sclk_s;
  logic       di_s;
  logic       hwpd_s;
  logic       comp_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so that no false serial clock edge or power down follows reset.
      sync_a <= 5'h10;
      sync_b <= 5'h10;
      sclk_d <= 1'b0;
    end else begin
      sync_a <= {cs_n_pin, sclk_pin, di_pin, hw_powerdown_pin, comp_pin};
      sync_b <= sync_a;
      sclk_d <= sclk_s;
    end
  end
  assign {cs_n_s, sclk_s, di_s, hwpd_s, comp_s} = sync_b;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  // Control register and core state.
  logic [1:0]            ctrl;
  sac_pkg::sac_state_e   state;
  sac_pkg::sac_state_e   next_state;
  logic [AB-1:0]         word;
  logic [3:0]            cnt;
  logic [RB-1:0]         shreg;
  logic                  sw_down;
  logic                  first_res;
  logic                  seen_res;
  logic [8:0]            rec_cnt;
  wire                   four_in   = ctrl[sac_pkg::CTRL_FOUR_INPUT];
  wire                   powered_dn = hwpd_s | sw_down | ctrl[sac_pkg::CTRL_FORCE_DOWN];

  logic          sar_start;
  logic          sar_busy;
  logic          sar_done;
  logic [RB-1:0] sar_trial;
  logic [RB-1:0] sar_result;

  sac_sar #(.N(RB)) u_sar (
    .clk    (pclk),
    .rst_n  (presetn),
    .start  (sar_start),
    .step   (sclk_rise),
    .comp   (comp_s),
    .trial  (sar_trial),
    .result (sar_result),
    .busy   (sar_busy),
    .done   (sar_done)
  );

  wire last_addr = sclk_rise && (cnt == 4'(AB - 1));
  wire last_acq  = sclk_rise && (cnt == 4'(sac_pkg::ACQ_CLKS - 1));
  wire last_out  = sclk_fall && (cnt == 4'(RB - 1));
  assign sar_start = (state == sac_pkg::S_ACQ) && last_acq;
  wire run_now     = word[AB-2];

  always_comb begin
    next_state = state;
    case (state)
      sac_pkg::S_OFF:   if (!hwpd_s) next_state = sac_pkg::S_HOLD;
      sac_pkg::S_HOLD:  if (cs_n_s) next_state = sac_pkg::S_READY;
      sac_pkg::S_READY: if (!cs_n_s) next_state = sac_pkg::S_ADDR;
      sac_pkg::S_ADDR: begin
        if (cs_n_s) next_state = sac_pkg::S_READY;
        else if (last_addr) next_state = run_now ? sac_pkg::S_ACQ : sac_pkg::S_HOLD;
      end
      sac_pkg::S_ACQ: begin
        if (cs_n_s) next_state = sac_pkg::S_READY;
        else if (last_acq) next_state = sac_pkg::S_CONV;
      end
      sac_pkg::S_CONV:  if (sar_done) next_state = sac_pkg::S_DONE;
      sac_pkg::S_DONE:  if (!cs_n_s) next_state = sac_pkg::S_SHIFT;
      sac_pkg::S_SHIFT: begin
        if (cs_n_s) next_state = sac_pkg::S_READY;
        else if (last_out) next_state = sac_pkg::S_HOLD;
      end
      default:          next_state = sac_pkg::S_HOLD;
    endcase
    if (hwpd_s) next_state = sac_pkg::S_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sac_pkg::S_HOLD;
      word  <= '0;
      cnt   <= '0;
      shreg <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) cnt <= '0;
      else if ((state == sac_pkg::S_SHIFT) ? sclk_fall : sclk_rise) cnt <= cnt + 4'h1;
      if (state == sac_pkg::S_ADDR && sclk_rise) word <= {word[AB-2:0], di_s};
      if (sar_done) shreg <= sar_result;
      else if (state == sac_pkg::S_SHIFT && sclk_fall) shreg <= {shreg[RB-2:0], 1'b0};
    end
  end

  // Software power down is held until a run command arrives; the hardware pin overrides.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_down   <= 1'b0;
      first_res <= 1'b0;
      seen_res  <= 1'b0;
      rec_cnt   <= '0;
    end else begin
      if (state == sac_pkg::S_ADDR && last_addr) sw_down <= ~run_now;
      if (sar_done) begin
        first_res <= ~seen_res;
        seen_res  <= 1'b1;
      end
      if (powered_dn) rec_cnt <= '0;
      else if (rec_cnt != 9'(sac_pkg::PU_RECOVERY_CYCLES)) rec_cnt <= rec_cnt + 9'h001;
    end
  end

  // Registered analog and pin outputs.
  wire        in_acq  = (state == sac_pkg::S_ACQ);
  wire        in_conv = (state == sac_pkg::S_CONV);
  wire [8:0]  sel     = chan_decode(word, four_in);
  wire        drive   = (state == sac_pkg::S_SHIFT) && !cs_n_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_pos_sel  <= '0;
      chan_neg_sel  <= '0;
      com_neg_sel   <= 1'b0;
      comp_zero     <= 1'b0;
      feedback_open <= 1'b0;
      cap_to_neg    <= 1'b0;
      bandgap_en    <= 1'b0;
      dac_switch    <= '0;
      do_pin        <= 1'b0;
      do_oe_n       <= 1'b1;
    end else begin
      chan_pos_sel  <= (in_acq && !powered_dn) ? sel[8:5] : 4'h0;
      chan_neg_sel  <= (in_conv && !powered_dn) ? sel[4:1] : 4'h0;
      com_neg_sel   <= in_conv && !powered_dn && sel[0];
      comp_zero     <= in_acq && !powered_dn;
      feedback_open <= in_conv && !powered_dn;
      cap_to_neg    <= in_conv && !powered_dn;
      bandgap_en    <= !powered_dn;
      dac_switch    <= sar_trial;
      do_pin        <= drive ? shreg[RB-1] : 1'b0;
      do_oe_n       <= !drive;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle.
  wire sel_ctrl = (paddr == sac_pkg::OFF_CTRL);
  wire sel_stat = (paddr == sac_pkg::OFF_STATUS);
  wire sel_res  = (paddr == sac_pkg::OFF_RESULT);
  wire hit      = sel_ctrl | sel_stat | sel_res;
  wire [31:0] stat_word = {24'h000000, state, first_res,
                           rec_cnt == 9'(sac_pkg::PU_RECOVERY_CYCLES),
                           state == sac_pkg::S_DONE, sar_busy, powered_dn};
  wire [31:0] res_word  = {11'h000, word, 5'h00, shreg};
  wire [31:0] rd_mux    = sel_ctrl ? {30'h00000000, ctrl} :
                          sel_stat ? stat_word :
                          sel_res  ? res_word  : 32'h00000000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= sac_pkg::CTRL_RESET;
      prdata <= '0;
    end else begin
      if (psel && !penable && !pwrite) prdata <= rd_mux;
      if (psel && penable && pwrite && sel_ctrl) ctrl <= pwdata[1:0];
    end
  end
endmodule
`default_nettype wire

// file: design/sac_pkg.sv
// Constants, register map and state encoding of the converter control block.
// Assumes the pclk rate given by CLK_HZ; sac_ctrl and tb refer here by name.
`default_nettype none
package sac_pkg;
  // Clock and timing.
  localparam int unsigned CLK_HZ             = 40_000_000;
  localparam int unsigned PU_RECOVERY_US     = 10;
  localparam int unsigned PU_RECOVERY_CYCLES = (PU_RECOVERY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ACQ_CLKS           = 2;
  localparam int unsigned CSH_MIN_CLKS       = 1;
  localparam int unsigned SC_MIN_CLKS        = 5;

  // Serial word and result.
  localparam int unsigned ASSIGN_BITS = 5;
  localparam int unsigned RESULT_BITS = 11;
  localparam int unsigned BIT_RUN     = 4;
  localparam int unsigned BIT_ENDED   = 3;
  localparam int unsigned BIT_ODD     = 2;
  localparam int unsigned BIT_HI      = 1;
  localparam int unsigned BIT_LO      = 0;
  localparam int unsigned NUM_CH      = 4;

  // Register map, byte addresses.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;

  // Control fields and reset value.
  localparam int unsigned CTRL_FORCE_DOWN = 0;
  localparam int unsigned CTRL_FOUR_INPUT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h2;

  // Status fields and result word position.
  localparam int unsigned ST_POWERED_DOWN = 0;
  localparam int unsigned ST_BUSY         = 1;
  localparam int unsigned ST_PENDING      = 2;
  localparam int unsigned ST_RECOVERED    = 3;
  localparam int unsigned ST_FIRST        = 4;
  localparam int unsigned ST_STATE_LSB    = 5;
  localparam int unsigned RES_WORD_LSB    = 16;

  typedef enum logic [2:0] {
    S_HOLD  = 3'b000,
    S_READY = 3'b001,
    S_ADDR  = 3'b010,
    S_ACQ   = 3'b011,
    S_CONV  = 3'b100,
    S_DONE  = 3'b101,
    S_SHIFT = 3'b110,
    S_OFF   = 3'b111
  } sac_state_e;
endpackage
`default_nettype wire

// file: design/sac_sar.sv
// Successive-approximation search: one comparator decision per step, MSB first.
// Assumes start and step are single-cycle pulses on clk and comp is already synchronised.
`default_nettype none
module sac_sar #(
  parameter int unsigned N = 11
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control.
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         comp,
  // Results.
  output logic [N-1:0]      trial,
  output logic [N-1:0]      result,
  output logic              busy,
  output logic              done
);
  localparam int unsigned IW = $clog2(N);
  localparam logic [IW-1:0] TOP = IW'(N - 1);

  logic [IW-1:0] idx;
  logic [N-1:0]  kept;
  logic [N-1:0]  probe;

  // A low comparator answer drops the bit under test; the next lower bit is then tried.
  assign kept  = comp ? trial : (trial & ~(N'(1) << idx));
  assign probe = (idx == '0) ? kept : (kept | (N'(1) << (idx - IW'(1))));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial  <= '0;
      result <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
      idx    <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        trial <= N'(1) << TOP;
        idx   <= TOP;
        busy  <= 1'b1;
      end else if (busy && step) begin
        trial <= probe;
        if (idx == '0) begin
          result <= kept;
          busy   <= 1'b0;
          done   <= 1'b1;
        end else begin
          idx <= idx - IW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/sac_ctrl_props.sv
// Checker on the analog switch and serial output pins of the converter control block.
// Assumes it is bound into sac_ctrl and sees its ports by name.
`default_nettype none
module sac_ctrl_props (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Watched pins.
  input wire logic       cs_n_pin,
  input wire logic       hw_powerdown_pin,
  input wire logic       do_pin,
  input wire logic       do_oe_n,
  input wire logic [3:0] chan_pos_sel,
  input wire logic [3:0] chan_neg_sel,
  input wire logic       com_neg_sel,
  input wire logic       comp_zero,
  input wire logic       feedback_open,
  input wire logic       cap_to_neg,
  input wire logic       bandgap_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HWPD_OFF: assert property (hw_powerdown_pin [*6] |-> !bandgap_en && !chan_pos_sel)
    else $error("reference or input on in power down");
  AST_ACQ: assert property (comp_zero |-> $onehot(chan_pos_sel) && !feedback_open)
    else $error("acquisition switches wrong");
  AST_POS_ONLY_ACQ: assert property (chan_pos_sel != 4'h0 |-> comp_zero && !cap_to_neg)
    else $error("positive input connected outside acquisition");
  AST_CONV: assert property (feedback_open |-> cap_to_neg && !comp_zero
    && $onehot({chan_neg_sel, com_neg_sel})) else $error("conversion switches wrong");
  AST_CONV_LEN: assert property ($rose(feedback_open) |-> feedback_open [*8])
    else $error("conversion ended too soon");
  AST_DO_IDLE: assert property (do_oe_n |-> !do_pin)
    else $error("data output not idle");
  AST_CS_DELAY: assert property (cs_n_pin [*6] |-> do_oe_n)
    else $error("data driven while select high");
  AST_PD_QUIET: assert property (!bandgap_en |-> !feedback_open && !comp_zero)
    else $error("switching while powered down");
endmodule
bind sac_ctrl sac_ctrl_props chk (
  .pclk             (pclk),
  .presetn          (presetn),
  .cs_n_pin         (cs_n_pin),
  .hw_powerdown_pin (hw_powerdown_pin),
  .do_pin           (do_pin),
  .do_oe_n          (do_oe_n),
  .chan_pos_sel     (chan_pos_sel),
  .chan_neg_sel     (chan_neg_sel),
  .com_neg_sel      (com_neg_sel),
  .comp_zero        (comp_zero),
  .feedback_open    (feedback_open),
  .cap_to_neg       (cap_to_neg),
  .bandgap_en       (bandgap_en)
);
`default_nettype wire

// file: testbench/sac_host.sv
// Host model: drives select, serial clock, assignment word and a comparator stand-in.
// Assumes the bench pclk; sclk runs at one sixteenth of it, only in convert, and keeps running while select is high before a gap.
`default_nettype none
module sac_host (
  // Bench clock.
  input  wire logic pclk,
  // Serial lines.
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      di_pin,
  output logic      comp_pin,
  input  wire logic do_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    di_pin = 1'b0;
    comp_pin = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge pclk);
  endtask
  // Inputs change while sclk is low; the data output is taken just before the fall.
  task automatic tick(input logic d, input logic c, output logic q);
    di_pin <= d;
    comp_pin <= c;
    half();
    sclk_pin <= 1'b1;
    half();
    q = do_pin;
    sclk_pin <= 1'b0;
  endtask
  task automatic convert(input logic [4:0] w, input logic [10:0] pat, input int gap,
                         output logic [10:0] res);
    logic q;
    cs_n_pin <= 1'b0;
    for (int i = 4; i >= 0; i--) tick(w[i], 1'b0, q);
    if (w[4]) begin
      repeat (2) tick(!di_pin, 1'b0, q);
      for (int i = 10; i >= 0; i--) begin
        tick(!di_pin, pat[i], q);
        if (gap > 0 && i == 8) cs_n_pin <= 1'b1;
      end
      repeat (gap) @(posedge pclk);
      cs_n_pin <= 1'b0;
      // With select held low the sign bit already stands before the last decision's fall.
      if (gap == 0) res[10] = q;
      for (int i = (gap == 0) ? 9 : 10; i >= 0; i--) begin
        tick(!di_pin, !comp_pin, q);
        res[i] = q;
      end
    end
    cs_n_pin <= 1'b1;
    repeat (12) half();
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench: APB tasks, the host model and direct drives of clock, reset and hw_powerdown_pin feed all inputs of sac_ctrl.
// Assumes the design package and the host model are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, hw_powerdown_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, cs_n_pin, sclk_pin, di_pin, do_pin, do_oe_n, comp_pin;
  logic [3:0]  chan_pos_sel, chan_neg_sel, pos_seen, neg_seen;
  logic        com_neg_sel, comp_zero, feedback_open, cap_to_neg, bandgap_en, com_seen;
  logic [10:0] dac_switch;
  int          bad_count = 0;
  int          checks_done = 0;
  sac_ctrl dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .cs_n_pin         (cs_n_pin),
    .sclk_pin         (sclk_pin),
    .di_pin           (di_pin),
    .do_pin           (do_pin),
    .do_oe_n          (do_oe_n),
    .hw_powerdown_pin (hw_powerdown_pin),
    .comp_pin         (comp_pin),
    .chan_pos_sel     (chan_pos_sel),
    .chan_neg_sel     (chan_neg_sel),
    .com_neg_sel      (com_neg_sel),
    .comp_zero        (comp_zero),
    .feedback_open    (feedback_open),
    .cap_to_neg       (cap_to_neg),
    .bandgap_en       (bandgap_en),
    .dac_switch       (dac_switch)
  );
  sac_host host (
    .pclk     (pclk),
    .cs_n_pin (cs_n_pin),
    .sclk_pin (sclk_pin),
    .di_pin   (di_pin),
    .comp_pin (comp_pin),
    .do_pin   (do_pin)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (comp_zero === 1'b1) pos_seen <= chan_pos_sel;
    if (feedback_open === 1'b1) {neg_seen, com_seen} <= {chan_neg_sel, com_neg_sel};
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1ms;
    bad_count++;
    complete_run();
  end
  initial begin
    logic [31:0] q;
    logic        e, fi, ed, od, lo;
    logic [10:0] r;
    logic [4:0]  w;
    logic [3:0]  ep, en;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hw_powerdown_pin = 1'b0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sac_pkg::OFF_CTRL, 32'h0, q, e);
    check("ctrl reset", sac_pkg::CTRL_RESET, q);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check("unmapped error", 1, e);
    host.convert(5'h18, 11'h000, 0, r);
    apb(1'b0, sac_pkg::OFF_STATUS, 32'h0, q, e);
    check("first flag", 1, q[4]);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      if (k == 8) apb(1'b1, sac_pkg::OFF_CTRL, 32'h0, q, e);
      fi = (k < 8);
      {ed, od, lo} = fi ? k[2:0] : {k[1:0], 1'b1};
      w = {1'b1, ed, od, 1'b0, lo};
      ep = 4'h1 << (fi ? {lo, od} : od);
      en = ed ? 4'h0 : 4'h1 << (fi ? {lo, !od} : !od);
      pos_seen = 'x;
      host.convert(w, 11'h5a5 ^ 11'(k), k[0] ? 300 : 0, r);
      check("positive input", ep, pos_seen);
      check("negative input", {en, ed}, {neg_seen, com_seen});
      check("result", 11'h5a5 ^ 11'(k), r);
      check("switches", 11'h5a5 ^ 11'(k), dac_switch);
      apb(1'b0, sac_pkg::OFF_RESULT, 32'h0, q, e);
      check("word", w, q[20:16]);
    end
    $display("test mux done");
    hw_powerdown_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    check("bandgap hw down", 0, bandgap_en);
    apb(1'b0, sac_pkg::OFF_STATUS, 32'h0, q, e);
    check("status down", 1, q[0]);
    check("state off", 7, q[7:5]);
    check("not recovered", 0, q[3]);
    check("first flag clear", 0, q[4]);
    hw_powerdown_pin <= 1'b0;
    repeat (sac_pkg::PU_RECOVERY_CYCLES) @(posedge pclk);
    check("bandgap back", 1, bandgap_en);
    host.convert(5'h0f, 11'h000, 0, r);
    check("bandgap soft down", 0, bandgap_en);
    host.convert(5'h18, 11'h000, 0, r);
    repeat (sac_pkg::PU_RECOVERY_CYCLES) @(posedge pclk);
    check("bandgap soft up", 1, bandgap_en);
    apb(1'b0, sac_pkg::OFF_STATUS, 32'h0, q, e);
    check("recovered", 1, q[3]);
    $display("test power done");
    complete_run();
  end
endmodule
`default_nettype wire
